// ### hdl/csrf_core_regs.sv
// core register set: general registers, banked stacks, link, counter, status
// Function
// RQ1: thirteen 32-bit general registers, reset undefined
// RQ2: register 13 picks stack by select bit
// RQ3: reset loads main stack from word zero
// RQ4: reset loads link register with printed value
// RQ5: reset loads program counter from word four
// RQ6: reset vector bit 0 sets state bit
// RQ7: status word combines three disjoint sub-fields
// RQ8: status moves touch only named views
// RQ9: writes never change exception number
// RQ10: state field reads zero, ignores writes
// RQ11: negative, zero, overflow flags at 31,30,28
// RQ12: carry flag at bit 29
// RQ13: saturation flag sticky until software clears
// RQ14: lane compare flags at bits 19:16
// RQ15: exception number encoding in bits 8:0
// RQ16: state bit 24, block state 26:25,15:10
// RQ17: entry stacks full status with state bits
// RQ18: privileged access for main stack, views, control
// RQ19: handler mode always uses main stack
// RQ20: interrupted multiple transfer records next operand
// RQ21: stack select reads zero in handler mode
// RQ22: reserved status bits read zero
// RQ23: hardware keeps exception number current
module csrf_core_regs
	import csrf_pkg::*;
#(
	parameter int NUM_GP = CSRF_NUM_GP
)
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// vector fetch port for the reset sequence
	output logic VEC_REQ,
	output logic [31:0] VEC_ADDR,
	input wire logic VEC_VALID,
	input wire logic [31:0] VEC_DATA,
	output logic CORE_READY,
	// execution privilege of the current instruction
	input wire logic PRIV,
	// register read
	input wire logic RD_EN,
	input wire logic [3:0] RD_SEL,
	output logic [31:0] RD_DATA,
	output logic RD_ERR,
	// register write
	input wire logic WR_EN,
	input wire logic [3:0] WR_SEL,
	input wire logic [31:0] WR_DATA,
	output logic WR_ERR,
	// program counter advance and link update
	input wire logic PC_LOAD,
	input wire logic [31:0] PC_NEXT,
	input wire logic LINK_LOAD,
	input wire logic [31:0] LINK_NEXT,
	// status move instructions
	input wire logic STAT_RD_EN,
	input wire logic STAT_WR_EN,
	input wire logic [2:0] STAT_VIEW,
	input wire logic [31:0] STAT_WR_DATA,
	output logic [31:0] STAT_RD_DATA,
	output logic STAT_ERR,
	// control register stack select
	input wire logic CTRL_WR_EN,
	input wire logic CTRL_WR_SEL,
	output logic STACK_SEL,
	// flag results from the datapath
	input wire logic FLAG_NZCV_EN,
	input wire logic FLAG_NEG,
	input wire logic FLAG_ZERO,
	input wire logic FLAG_CARRY,
	input wire logic FLAG_OVF,
	input wire logic FLAG_LANE_EN,
	input wire logic [3:0] FLAG_LANE,
	input wire logic SAT_HIT,
	// execution state updates
	input wire logic STATE_WR_EN,
	input wire logic [31:0] STATE_WR_DATA,
	input wire logic RESUME_SAVE,
	input wire logic [3:0] RESUME_OPERAND,
	// exception entry and return
	input wire logic EXC_ENTRY,
	input wire logic [8:0] EXC_NUMBER,
	input wire logic EXC_RETURN,
	input wire logic [31:0] EXC_RESTORE_STATUS,
	input wire logic EXC_RESTORE_SEL,
	output logic [31:0] STACKED_STATUS,
	output logic [31:0] STATUS,
	output logic HANDLER_MODE,
	output logic EXC_NUMBER_BAD
);
	initial
	begin
		if (NUM_GP != CSRF_NUM_GP)
			$error("csrf_core_regs: NUM_GP must be thirteen");
	end

	typedef enum {
		CSRF_ST_FETCH_SP,
		CSRF_ST_FETCH_PC,
		CSRF_ST_RUN
	} csrf_boot_t;

	csrf_boot_t boot_state;
	logic [31:0] gp_regs [NUM_GP];
	logic [31:0] main_sp;
	logic [31:0] proc_sp;
	logic [31:0] link;
	logic [31:0] pc;
	logic [31:0] flags;
	logic [8:0] exc_num;
	logic [31:0] exec_state;
	logic stack_sel;
	logic use_proc;
	logic in_handler;
	logic [31:0] full_status;
	logic [31:0] rd_mask;
	logic [31:0] wr_mask;
	logic exc_ok;
	logic running;
	logic next_sat;
	logic gp_wr;
	logic sp_denied;
	logic stat_wr_ok;

	assign running = (boot_state == CSRF_ST_RUN);
	assign in_handler = (exc_num != CSRF_EXC_THREAD);
	// handler mode forces the main stack whatever the select bit says
	assign use_proc = stack_sel && !in_handler; // RQ2 RQ19
	// disjoint fields; reserved positions are held at zero by the masks
	assign full_status = (flags & CSRF_MASK_FLAGS) | {23'h000000, exc_num}
		| (exec_state & CSRF_MASK_STATE); // RQ7 RQ22
	// the main stack needs privilege only when register 13 resolves to it
	assign sp_denied = !PRIV && !use_proc;
	assign gp_wr = WR_EN && running && WR_SEL < CSRF_REG_SP;
	// an unprivileged write through a view naming number or state is refused whole
	assign stat_wr_ok = STAT_WR_EN && running && (PRIV || STAT_VIEW[2:1] == 2'b00); // RQ18

	csrf_view_mask u_view_mask (
		.view(STAT_VIEW),
		.read_mask(rd_mask),
		.write_mask(wr_mask)
	);

	csrf_exc_check u_exc_check (
		.number(EXC_NUMBER),
		.valid(exc_ok)
	);

	// reset sequence: stack word first, then reset vector
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			boot_state <= CSRF_ST_FETCH_SP;
		else
		begin
			case (boot_state)
				CSRF_ST_FETCH_SP:
					if (VEC_VALID)
						boot_state <= CSRF_ST_FETCH_PC;
				CSRF_ST_FETCH_PC:
					if (VEC_VALID)
						boot_state <= CSRF_ST_RUN;
				default:
					boot_state <= CSRF_ST_RUN;
			endcase
		end
	end

	// vector request outputs registered ahead of the state they serve
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			VEC_REQ <= 1'b1;
			VEC_ADDR <= CSRF_VEC_STACK_ADDR; // RQ3
			CORE_READY <= 1'b0;
		end
		else
		begin
			VEC_REQ <= !(boot_state == CSRF_ST_RUN
				|| (boot_state == CSRF_ST_FETCH_PC && VEC_VALID));
			if (boot_state == CSRF_ST_FETCH_SP && VEC_VALID)
				VEC_ADDR <= CSRF_VEC_RESET_ADDR; // RQ5
			CORE_READY <= boot_state == CSRF_ST_RUN
				|| (boot_state == CSRF_ST_FETCH_PC && VEC_VALID);
		end
	end

	// general registers: no reset, contents undefined until written
	genvar gi;
	generate
		for (gi = 0; gi < NUM_GP; gi++)
		begin : g_gp
			always_ff @(posedge CLK_SYS)
			begin
				if (gp_wr && WR_SEL == 4'(gi))
					gp_regs[gi] <= WR_DATA; // RQ1
			end
		end
	endgenerate

	// banked stack pointers; main stack comes from the table at reset
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			main_sp <= CSRF_ZERO;
		else if (boot_state == CSRF_ST_FETCH_SP && VEC_VALID)
			main_sp <= VEC_DATA; // RQ3
		else if (WR_EN && running && WR_SEL == CSRF_REG_SP && !use_proc && PRIV)
			main_sp <= WR_DATA; // RQ18
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (WR_EN && running && WR_SEL == CSRF_REG_SP && use_proc)
			proc_sp <= WR_DATA; // RQ2
	end

	// link register
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			link <= CSRF_LINK_RESET; // RQ4
		else if (LINK_LOAD && running)
			link <= LINK_NEXT;
		else if (WR_EN && running && WR_SEL == CSRF_REG_LINK)
			link <= WR_DATA;
	end

	// program counter, loaded from the reset vector
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			pc <= CSRF_ZERO;
		else if (boot_state == CSRF_ST_FETCH_PC && VEC_VALID)
			pc <= VEC_DATA; // RQ5
		else if (WR_EN && running && WR_SEL == CSRF_REG_PC)
			pc <= WR_DATA;
		else if (PC_LOAD && running)
			pc <= PC_NEXT;
	end

	// stack select; writes ignored in handler mode, restored on return
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			stack_sel <= 1'b0; // RQ2
		else if (EXC_RETURN)
			stack_sel <= EXC_RESTORE_SEL;
		else if (CTRL_WR_EN && PRIV && !in_handler)
			stack_sel <= CTRL_WR_SEL; // RQ21 RQ18
	end

	// saturation: a hit in the same cycle as a software clear wins
	always_comb
	begin
		next_sat = flags[CSRF_BIT_SAT];
		if (EXC_RETURN)
			next_sat = EXC_RESTORE_STATUS[CSRF_BIT_SAT];
		else if (stat_wr_ok && wr_mask[CSRF_BIT_SAT])
			next_sat = STAT_WR_DATA[CSRF_BIT_SAT];
		if (SAT_HIT)
			next_sat = 1'b1; // RQ13
	end

	// arithmetic flags: datapath results beat a same-cycle status write
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			flags <= CSRF_ZERO;
		else
		begin
			if (EXC_RETURN)
				flags <= EXC_RESTORE_STATUS & CSRF_MASK_FLAGS;
			else if (stat_wr_ok)
				flags <= (flags & ~wr_mask) | (STAT_WR_DATA & wr_mask); // RQ8 RQ22
			if (FLAG_NZCV_EN)
			begin
				flags[CSRF_BIT_NEG] <= FLAG_NEG; // RQ11
				flags[CSRF_BIT_ZERO] <= FLAG_ZERO; // RQ11
				flags[CSRF_BIT_CARRY] <= FLAG_CARRY; // RQ12
				flags[CSRF_BIT_OVF] <= FLAG_OVF; // RQ11
			end
			if (FLAG_LANE_EN)
				flags[19:16] <= FLAG_LANE; // RQ14
			flags[CSRF_BIT_SAT] <= next_sat; // RQ13
		end
	end

	// exception number changes only by entry and return, never by a write
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			exc_num <= CSRF_EXC_THREAD;
		else if (EXC_ENTRY && exc_ok)
			exc_num <= EXC_NUMBER; // RQ23 RQ15 RQ9
		else if (EXC_RETURN)
			exc_num <= EXC_RESTORE_STATUS[8:0]; // RQ23
	end

	// execution state: vector bit 0 gives the state bit at reset
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			exec_state <= CSRF_STATUS_RESET;
		else if (boot_state == CSRF_ST_FETCH_PC && VEC_VALID)
		begin
			exec_state <= CSRF_ZERO;
			exec_state[CSRF_BIT_TSTATE] <= VEC_DATA[0]; // RQ6
		end
		else if (EXC_RETURN)
			exec_state <= EXC_RESTORE_STATUS & CSRF_MASK_STATE; // RQ16
		else if (RESUME_SAVE)
			// block-state bits outside the operand field 15:12 are zero while a transfer is held
			exec_state <= (32'(RESUME_OPERAND) << CSRF_RESUME_LSB)
				| (exec_state & (32'(1) << CSRF_BIT_TSTATE)); // RQ20
		else if (STATE_WR_EN)
			exec_state <= STATE_WR_DATA & CSRF_MASK_STATE; // RQ16
	end

	// register read port; main stack needs privilege
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			RD_DATA <= CSRF_ZERO;
			RD_ERR <= 1'b0;
		end
		else if (RD_EN)
		begin
			RD_ERR <= 1'b0;
			if (RD_SEL < CSRF_REG_SP)
				RD_DATA <= gp_regs[RD_SEL];
			else if (RD_SEL == CSRF_REG_SP)
			begin
				RD_DATA <= use_proc ? proc_sp : (sp_denied ? CSRF_ZERO : main_sp);
				RD_ERR <= sp_denied; // RQ18
			end
			else if (RD_SEL == CSRF_REG_LINK)
				RD_DATA <= link;
			else
				RD_DATA <= pc;
		end
	end

	// write refusal report for register 13
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			WR_ERR <= 1'b0;
		else
			WR_ERR <= WR_EN && running && WR_SEL == CSRF_REG_SP && sp_denied; // RQ18
	end

	// status read through a view; state bits always read zero
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			STAT_RD_DATA <= CSRF_ZERO;
			STAT_ERR <= 1'b0;
		end
		else
		begin
			STAT_ERR <= (STAT_RD_EN || STAT_WR_EN) && !PRIV && STAT_VIEW[2:1] != 2'b00; // RQ18
			if (STAT_RD_EN)
				STAT_RD_DATA <= full_status & rd_mask
					& ((PRIV || STAT_VIEW[2:1] == 2'b00) ? 32'hffff_ffff : CSRF_ZERO); // RQ10 RQ8
		end
	end

	// stacked copy at entry includes execution state
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			STACKED_STATUS <= CSRF_ZERO;
		else if (EXC_ENTRY)
			STACKED_STATUS <= full_status; // RQ17
	end

	// status and mode mirrors
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			STATUS <= CSRF_STATUS_RESET;
			HANDLER_MODE <= 1'b0;
			STACK_SEL <= 1'b0;
			EXC_NUMBER_BAD <= 1'b0;
		end
		else
		begin
			STATUS <= full_status;
			HANDLER_MODE <= in_handler;
			STACK_SEL <= stack_sel && !in_handler; // RQ21
			EXC_NUMBER_BAD <= EXC_ENTRY && !exc_ok;
		end
	end
endmodule : csrf_core_regs

// ### hdl/csrf_pkg.sv
// constants, field layout and reset values for the core register set
package csrf_pkg;
	localparam int CSRF_XLEN = 32;
	localparam int CSRF_NUM_GP = 13;
	// register numbers
	localparam logic [3:0] CSRF_REG_SP = 4'hd;
	localparam logic [3:0] CSRF_REG_LINK = 4'he;
	localparam logic [3:0] CSRF_REG_PC = 4'hf;
	// vector table addresses
	localparam logic [31:0] CSRF_VEC_STACK_ADDR = 32'h0000_0000;
	localparam logic [31:0] CSRF_VEC_RESET_ADDR = 32'h0000_0004;
	// reset values
	localparam logic [31:0] CSRF_LINK_RESET = 32'h0fff_ffff;
	localparam logic [31:0] CSRF_STATUS_RESET = 32'h0100_0000;
	localparam logic [31:0] CSRF_ZERO = 32'h0000_0000;
	// flag, state and stack select bit positions
	localparam int CSRF_BIT_NEG = 31;
	localparam int CSRF_BIT_ZERO = 30;
	localparam int CSRF_BIT_CARRY = 29;
	localparam int CSRF_BIT_OVF = 28;
	localparam int CSRF_BIT_SAT = 27;
	localparam int CSRF_BIT_TSTATE = 24;
	localparam int CSRF_STACK_SEL_BIT = 1;
	// field masks of the combined status word
	localparam logic [31:0] CSRF_MASK_FLAGS = 32'hf80f_0000;
	localparam logic [31:0] CSRF_MASK_NUMBER = 32'h0000_01ff;
	localparam logic [31:0] CSRF_MASK_STATE = 32'h0700_fc00;
	localparam logic [31:0] CSRF_MASK_RESUME = 32'h0000_f000;
	localparam int CSRF_RESUME_LSB = 12;
	// exception numbers
	localparam logic [8:0] CSRF_EXC_THREAD = 9'h000;
	localparam logic [8:0] CSRF_EXC_NMI = 9'h002;
	localparam logic [8:0] CSRF_EXC_HARD = 9'h003;
	localparam logic [8:0] CSRF_EXC_MEM = 9'h004;
	localparam logic [8:0] CSRF_EXC_BUS = 9'h005;
	localparam logic [8:0] CSRF_EXC_USAGE = 9'h006;
	localparam logic [8:0] CSRF_EXC_SVC = 9'h00b;
	localparam logic [8:0] CSRF_EXC_PENDED_SERVICE_EXCEPTION = 9'h00e;
	localparam logic [8:0] CSRF_EXC_TICK = 9'h00f;
	localparam logic [8:0] CSRF_EXC_IRQ_FIRST = 9'h010;
	localparam logic [8:0] CSRF_EXC_IRQ_LAST = 9'h02d;
	// status view selectors: bit 0 flags, bit 1 number, bit 2 state
	typedef enum logic [2:0] {
		CSRF_VIEW_NONE = 3'h0,
		CSRF_VIEW_FLAGS = 3'h1,
		CSRF_VIEW_NUMBER = 3'h2,
		CSRF_VIEW_FLAGS_NUMBER = 3'h3,
		CSRF_VIEW_STATE = 3'h4,
		CSRF_VIEW_FLAGS_STATE = 3'h5,
		CSRF_VIEW_NUMBER_STATE = 3'h6,
		CSRF_VIEW_ALL = 3'h7
	} csrf_view_t;
endpackage : csrf_pkg

// ### hdl/csrf_view_mask.sv
// field masks for a named status view, separately for reads and writes
module csrf_view_mask
	import csrf_pkg::*;
(
	input wire logic [2:0] view,
	output logic [31:0] read_mask,
	output logic [31:0] write_mask
);
	// state bits never show or take writes; number bits never take writes
	always_comb
	begin
		read_mask = CSRF_ZERO;
		write_mask = CSRF_ZERO;
		if (view[0])
		begin
			read_mask = read_mask | CSRF_MASK_FLAGS;
			write_mask = CSRF_MASK_FLAGS;
		end
		if (view[1])
			read_mask = read_mask | CSRF_MASK_NUMBER;
	end
endmodule : csrf_view_mask

// ### hdl/csrf_exc_check.sv
// classifies an exception number as defined or reserved
module csrf_exc_check
	import csrf_pkg::*;
(
	input wire logic [8:0] number,
	output logic valid
);
	always_comb
	begin
		valid = 1'b0;
		if (number >= CSRF_EXC_IRQ_FIRST && number <= CSRF_EXC_IRQ_LAST)
			valid = 1'b1;
		else if (number == CSRF_EXC_THREAD || number == CSRF_EXC_NMI || number == CSRF_EXC_HARD
			|| number == CSRF_EXC_MEM || number == CSRF_EXC_BUS || number == CSRF_EXC_USAGE
			|| number == CSRF_EXC_SVC || number == CSRF_EXC_PENDED_SERVICE_EXCEPTION || number == CSRF_EXC_TICK)
			valid = 1'b1;
	end
endmodule : csrf_exc_check

// ### sim/csrf_core_regs_props.sv
// concurrent checks on the core register set ports
module csrf_core_regs_props
	import csrf_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic VEC_REQ,
	input wire logic [31:0] VEC_ADDR,
	input wire logic VEC_VALID,
	input wire logic [31:0] VEC_DATA,
	input wire logic CORE_READY,
	input wire logic PRIV,
	input wire logic STAT_RD_EN,
	input wire logic STAT_WR_EN,
	input wire logic [2:0] STAT_VIEW,
	input wire logic [31:0] STAT_RD_DATA,
	input wire logic STAT_ERR,
	input wire logic FLAG_NZCV_EN,
	input wire logic FLAG_NEG,
	input wire logic FLAG_ZERO,
	input wire logic FLAG_CARRY,
	input wire logic FLAG_OVF,
	input wire logic EXC_ENTRY,
	input wire logic [8:0] EXC_NUMBER,
	input wire logic EXC_RETURN,
	input wire logic [31:0] STACKED_STATUS,
	input wire logic [31:0] STATUS,
	input wire logic HANDLER_MODE,
	input wire logic STACK_SEL
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);
	// the two steps of the boot fetch
	sequence s_vec_first;
		VEC_REQ && VEC_VALID && VEC_ADDR == CSRF_VEC_STACK_ADDR;
	endsequence
	sequence s_vec_last;
		VEC_REQ && VEC_VALID && VEC_ADDR == CSRF_VEC_RESET_ADDR && !CORE_READY;
	endsequence
	chk_vec_order: assert property (s_vec_first |=> VEC_ADDR == CSRF_VEC_RESET_ADDR)
		else $error("vector address did not step to four");
	// the status mirror trails the registers by one edge, so results show two edges on
	chk_boot_done: assert property (s_vec_last |=> CORE_READY
		##1 STATUS[24] == $past(VEC_DATA[0], 2))
		else $error("boot end or state bit wrong");
	// a flag load followed by a cycle with no flag load, status write or return
	sequence s_flag_load;
		FLAG_NZCV_EN ##1 !FLAG_NZCV_EN && !STAT_WR_EN && !EXC_RETURN;
	endsequence
	chk_flag_load: assert property (s_flag_load
		|=> STATUS[31:28] == $past({FLAG_NEG, FLAG_ZERO, FLAG_CARRY, FLAG_OVF}, 2))
		else $error("flags not loaded");
	chk_sat_sticky: assert property (STATUS[27] && !$past(STAT_WR_EN && STAT_VIEW[0])
		&& !$past(EXC_RETURN) |=> STATUS[27])
		else $error("saturation flag dropped");
	chk_number_kept: assert property (STAT_WR_EN && !EXC_ENTRY && !EXC_RETURN
		|=> ##1 STATUS[8:0] == $past(STATUS[8:0]))
		else $error("status write changed number");
	chk_state_reads_zero: assert property (STAT_RD_EN |=> (STAT_RD_DATA & CSRF_MASK_STATE) == 0)
		else $error("state bits visible on read");
	chk_unpriv_view: assert property (STAT_RD_EN && !PRIV && STAT_VIEW[2:1] != 0
		|=> STAT_ERR && STAT_RD_DATA == 0)
		else $error("unprivileged view not refused");
	chk_irq_number: assert property (EXC_ENTRY && EXC_NUMBER >= 16 && EXC_NUMBER <= 45
		|=> ##1 STATUS[8:0] == $past(EXC_NUMBER, 2) && HANDLER_MODE)
		else $error("interrupt number not loaded");
	chk_entry_stack: assert property (EXC_ENTRY |=> STACKED_STATUS == STATUS)
		else $error("stacked status differs");
	chk_handler_msp: assert property (HANDLER_MODE && $past(HANDLER_MODE) |-> !STACK_SEL)
		else $error("process stack in handler");
	chk_reserved_zero: assert property (CORE_READY
		|-> (STATUS & ~(CSRF_MASK_FLAGS | CSRF_MASK_NUMBER | CSRF_MASK_STATE)) == 0)
		else $error("reserved status bit set");
endmodule : csrf_core_regs_props

bind csrf_core_regs csrf_core_regs_props u_chk (.*);

// ### sim/csrf_core_regs_test.sv
// self-checking bench for the core register set
module csrf_core_regs_test import csrf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] RESTORE = 32'h990a_0000;
	logic CLK_SYS, RST_B, VEC_VALID, PRIV, RD_EN, WR_EN, PC_LOAD, LINK_LOAD, STAT_RD_EN;
	logic STAT_WR_EN, CTRL_WR_EN, CTRL_WR_SEL, FLAG_NZCV_EN, FLAG_NEG, FLAG_ZERO, FLAG_CARRY;
	logic FLAG_OVF, FLAG_LANE_EN, SAT_HIT, STATE_WR_EN, RESUME_SAVE, EXC_ENTRY, EXC_RETURN;
	logic EXC_RESTORE_SEL, VEC_REQ, CORE_READY, RD_ERR, WR_ERR, STAT_ERR, STACK_SEL;
	logic HANDLER_MODE, EXC_NUMBER_BAD, e;
	logic [3:0] RD_SEL, WR_SEL, FLAG_LANE, RESUME_OPERAND;
	logic [2:0] STAT_VIEW;
	logic [8:0] EXC_NUMBER;
	logic [31:0] VEC_DATA, WR_DATA, PC_NEXT, LINK_NEXT, STAT_WR_DATA, STATE_WR_DATA;
	logic [31:0] EXC_RESTORE_STATUS, VEC_ADDR, RD_DATA, STAT_RD_DATA, STACKED_STATUS, STATUS, d;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	csrf_core_regs uut (.*);
	initial
	begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// inputs always move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask : tick
	// strobes get a quiet cycle after, so no signal is set twice in one step
	task automatic pulse(ref logic x);
		x = 1'b1;
		tick(1);
		x = 1'b0;
		tick(1);
	endtask : pulse
	task automatic rd(input logic [3:0] s);
		RD_EN = 1'b1;
		RD_SEL = s;
		tick(1);
		RD_EN = 1'b0;
		d = RD_DATA;
		e = RD_ERR;
		tick(1);
	endtask : rd
	task automatic wr(input logic [3:0] s, input logic [31:0] w);
		WR_EN = 1'b1;
		WR_SEL = s;
		WR_DATA = w;
		tick(1);
		WR_EN = 1'b0;
		e = WR_ERR;
		tick(1);
	endtask : wr
	task automatic srd(input logic [2:0] v);
		STAT_RD_EN = 1'b1;
		STAT_VIEW = v;
		tick(1);
		STAT_RD_EN = 1'b0;
		d = STAT_RD_DATA;
		e = STAT_ERR;
		tick(1);
	endtask : srd
	task automatic swr(input logic [2:0] v, input logic [31:0] w);
		STAT_VIEW = v;
		STAT_WR_DATA = w;
		pulse(STAT_WR_EN);
	endtask : swr
	// released vector bus shows inverted data, not the last word
	task automatic vec(input logic [31:0] a, input logic [31:0] w);
		for (int i = 0; i < 20 && VEC_REQ !== 1'b1; i++)
			tick(1);
		chk(VEC_ADDR, a);
		VEC_VALID = 1'b1;
		VEC_DATA = w;
		tick(1);
		VEC_VALID = 1'b0;
		VEC_DATA = ~w;
		tick(1);
	endtask : vec
	task automatic t_boot(input logic [31:0] sp, input logic [31:0] pc);
		RST_B = 1'b0;
		tick(10);
		chk(STATUS, CSRF_STATUS_RESET);
		RST_B = 1'b1;
		vec(CSRF_VEC_STACK_ADDR, sp);
		vec(CSRF_VEC_RESET_ADDR, pc);
		chk(CORE_READY, 1'b1);
		chk(STATUS[24], pc[0]);
		chk(STACK_SEL, 1'b0);
		rd(CSRF_REG_SP);
		chk(d, sp);
		rd(CSRF_REG_PC);
		chk(d[31:1], pc[31:1]);
		rd(CSRF_REG_LINK);
		chk(d, CSRF_LINK_RESET);
	endtask : t_boot
	task automatic t_regs;
		PRIV = 1'b0;
		for (int s = 0; s < 13; s += 12)
		begin
			wr(s[3:0], 32'ha5a5_0000 | s);
			rd(s[3:0]);
			chk(d, 32'ha5a5_0000 | s);
		end
		wr(CSRF_REG_SP, 32'h1);
		chk(e, 1'b1);
		rd(CSRF_REG_SP);
		chk(e, 1'b1);
		chk(d, 32'h0);
		PRIV = 1'b1;
		wr(CSRF_REG_SP, 32'h2000_0800);
		CTRL_WR_SEL = 1'b1;
		pulse(CTRL_WR_EN);
		chk(STACK_SEL, 1'b1);
		wr(CSRF_REG_SP, 32'h2000_0400);
		PRIV = 1'b0;
		rd(CSRF_REG_SP);
		chk(d, 32'h2000_0400);
		PRIV = 1'b1;
		CTRL_WR_SEL = 1'b0;
		pulse(CTRL_WR_EN);
		rd(CSRF_REG_SP);
		chk(d, 32'h2000_0800);
		PC_NEXT = 32'h0000_0300;
		LINK_NEXT = 32'h0000_0151;
		pulse(PC_LOAD);
		pulse(LINK_LOAD);
		rd(CSRF_REG_PC);
		chk(d, PC_NEXT);
		rd(CSRF_REG_LINK);
		chk(d, LINK_NEXT);
	endtask : t_regs
	task automatic t_flags;
		for (int i = 0; i < 16; i++)
		begin
			{FLAG_NEG, FLAG_ZERO, FLAG_CARRY, FLAG_OVF} = i[3:0];
			pulse(FLAG_NZCV_EN);
			chk(STATUS[31:28], i[3:0]);
		end
		FLAG_LANE = 4'ha;
		pulse(FLAG_LANE_EN);
		chk(STATUS[19:16], 4'ha);
		// a hit in the same cycle as a clearing write must leave the flag set
		STAT_VIEW = CSRF_VIEW_FLAGS;
		STAT_WR_DATA = 32'h0;
		{SAT_HIT, STAT_WR_EN} = 2'b11;
		tick(1);
		{SAT_HIT, STAT_WR_EN} = 2'b00;
		tick(1);
		chk(STATUS[CSRF_BIT_SAT], 1'b1);
		pulse(SAT_HIT);
		pulse(FLAG_NZCV_EN);
		chk(STATUS[CSRF_BIT_SAT], 1'b1);
		swr(CSRF_VIEW_FLAGS, 32'h0);
		chk(STATUS[CSRF_BIT_SAT], 1'b0);
	endtask : t_flags
	// entry; a reserved number is refused and leaves thread mode alone
	task automatic ent(input logic [8:0] n, input logic bad);
		EXC_NUMBER = n;
		EXC_ENTRY = 1'b1;
		tick(1);
		EXC_ENTRY = 1'b0;
		chk(EXC_NUMBER_BAD, bad);
		tick(1);
		chk(STATUS[8:0], bad ? 9'h0 : n);
		chk(HANDLER_MODE, !bad);
		chk(STACK_SEL, bad);
	endtask : ent
	task automatic t_exc;
		logic [8:0] nums [12] = '{2, 3, 4, 5, 6, 11, 14, 15, 16, 45, 7, 46};
		EXC_RESTORE_STATUS = RESTORE;
		EXC_RESTORE_SEL = 1'b1;
		CTRL_WR_SEL = 1'b1;
		pulse(CTRL_WR_EN);
		foreach (nums[i])
		begin
			ent(nums[i], i > 9);
			if (i < 10)
				pulse(EXC_RETURN);
			chk(STACK_SEL, 1'b1);
		end
		STATE_WR_DATA = 32'h0700_0000;
		pulse(STATE_WR_EN);
		chk(STATUS[26:24], 3'h7);
		STATE_WR_DATA = CSRF_STATUS_RESET;
		pulse(STATE_WR_EN);
		RESUME_OPERAND = 4'h9;
		pulse(RESUME_SAVE);
		chk(STATUS[15:12], 4'h9);
		ent(CSRF_EXC_IRQ_LAST, 1'b0);
		chk(STACKED_STATUS[15:12], 4'h9);
		chk(STACKED_STATUS[24], 1'b1);
		pulse(CTRL_WR_EN);
		chk(STACK_SEL, 1'b0);
		swr(CSRF_VIEW_ALL, 32'hffff_ffff);
		chk(STATUS[8:0], CSRF_EXC_IRQ_LAST);
		chk(STATUS[26:24], 3'h1);
		for (int v = 0; v < 8; v++)
		begin
			srd(v[2:0]);
			chk(d, (v[0] ? CSRF_MASK_FLAGS : 32'h0) | (v[1] ? 32'h2d : 32'h0));
		end
		pulse(EXC_RETURN);
		PRIV = 1'b0;
		for (int v = 0; v < 8; v++)
		begin
			srd(v[2:0]);
			chk(e, v[2:1] != 0);
			chk(d, v == 1 ? (RESTORE & CSRF_MASK_FLAGS) : 32'h0);
		end
		swr(CSRF_VIEW_FLAGS_NUMBER, 32'h0);
		chk(STATUS[31:27], 5'h13);
		PRIV = 1'b1;
	endtask : t_exc
	initial
	begin
		{RST_B, VEC_VALID, RD_EN, WR_EN, PC_LOAD, LINK_LOAD, STAT_RD_EN, STAT_WR_EN} = '0;
		{CTRL_WR_EN, CTRL_WR_SEL, FLAG_NZCV_EN, FLAG_NEG, FLAG_ZERO, FLAG_CARRY, FLAG_OVF} = '0;
		{FLAG_LANE_EN, SAT_HIT, STATE_WR_EN, RESUME_SAVE, EXC_ENTRY, EXC_RETURN} = '0;
		{EXC_RESTORE_SEL, RD_SEL, WR_SEL, FLAG_LANE, RESUME_OPERAND, STAT_VIEW, EXC_NUMBER} = '0;
		{VEC_DATA, WR_DATA, PC_NEXT, LINK_NEXT, STAT_WR_DATA, STATE_WR_DATA} = '0;
		EXC_RESTORE_STATUS = '0;
		PRIV = 1'b1;
		#1;
		t_boot(32'h2000_1000, 32'h0000_0201);
		t_regs;
		t_flags;
		t_exc;
		t_boot(32'h2000_2000, 32'h0000_0401);
		end_sim;
	end
	// cut a hang short
	always @(posedge CLK_SYS)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			end_sim;
		end
	end
endmodule : csrf_core_regs_test
